// *** core/mprf_pkg.sv ***
package mprf_pkg;

    // message type codes, high nibble of the first byte
    localparam logic [3:0] TYPE_QUERY = 4'h7;
    localparam logic [3:0] TYPE_BITMAP = 4'h8;
    localparam logic [3:0] TYPE_LIST = 4'h9;
    localparam logic [3:0] TYPE_STATE = 4'h5;
    localparam logic [1:0] PROTO_VERSION = 2'h0;
    localparam logic [1:0] HDR_RESERVED = 2'h0;

    // header field positions in the first byte
    localparam int HDR_TYPE_MSB = 7;
    localparam int HDR_TYPE_LSB = 4;
    localparam int HDR_VER_MSB = 3;
    localparam int HDR_VER_LSB = 2;

    // upgrade states as reported in the state reply
    localparam logic [3:0] UPG_RECEIVING = 4'h1;
    localparam logic [3:0] UPG_EXCEPTION = 4'h5;

    // page length choices in bytes, selected by a 2-bit code
    localparam logic [7:0] PLEN_32 = 8'h20;
    localparam logic [7:0] PLEN_64 = 8'h40;
    localparam logic [7:0] PLEN_128 = 8'h80;
    localparam logic [7:0] PLEN_192 = 8'hc0;

    // query layout: header byte plus four page number bytes
    localparam logic [2:0] QUERY_LAST_IDX = 3'h4;

    // value after reset, and default page map size
    localparam logic [31:0] RCV_COUNT_RST = 32'h0000_0000;
    localparam int DEF_MAX_PAGES = 4096;

    typedef enum logic [3:0] {
        MPRF_S_PARSE = 4'b0000,
        MPRF_S_DROP = 4'b0001,
        MPRF_S_START = 4'b0010,
        MPRF_S_SEARCH = 4'b0011,
        MPRF_S_HDR = 4'b0100,
        MPRF_S_WORD = 4'b0101,
        MPRF_S_BITS = 4'b0110,
        MPRF_S_LSCAN = 4'b0111
    } mprf_state_t;

    typedef enum logic [2:0] {
        MPRF_F_COUNT = 3'b000,
        MPRF_F_FIRST = 3'b001,
        MPRF_F_LIST = 3'b010,
        MPRF_F_STATE = 3'b011,
        MPRF_F_CRC = 3'b100,
        MPRF_F_EXC = 3'b101
    } mprf_fld_t;

endpackage : mprf_pkg

// *** core/mprf_buf.sv ***
`timescale 1ns/1ps

module mprf_buf #(
    parameter int WIDTH = 9
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("mprf_buf WIDTH must be at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] head_ff;
    logic [WIDTH-1:0] tail_ff;
    logic [1:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // two slots let the framer keep going one beat while the receiver stalls
    assign in_ready = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data = head_ff;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_ff <= 2'h0;
            head_ff <= '0;
            tail_ff <= '0;
        end else begin
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 2'h1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
            if (pop) begin
                head_ff <= (push && cnt_ff == 2'h1) ? in_data : tail_ff;
            end else if (push && cnt_ff == 2'h0) begin
                head_ff <= in_data;
            end
            if (push && ((cnt_ff == 2'h1 && !pop) || (cnt_ff == 2'h2 && pop))) begin
                tail_ff <= in_data;
            end
        end
    end

endmodule : mprf_buf

// *** core/mprf_framer.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// (RQ1) far end sends query to learn missing
// (RQ2) receiving state: exactly one report reply
// (RQ3) other states: answer with state reply
// (RQ4) header: type, zero version, zero reserved
// (RQ5) query carries 32-bit starting page number
// (RQ6) bitmap reply carries 32-bit received count
// (RQ7) then 32-bit number of first page
// (RQ8) first page equals query or later
// (RQ9) nothing missing after query: search from zero
// (RQ10) bitmap bits msb first, consecutive pages
// (RQ11) bit one missing, zero received
// (RQ12) bitmap may wrap past last page
// (RQ13) bitmap at most page length bytes
// (RQ14) bitmap or list form freely chosen
// (RQ15) far end understands both reply forms
// (RQ16) checksum busy: empty report reply
// (RQ17) page length 32, 64, 128, 192 bytes
// (RQ18) list entries are 32-bit page numbers
// (RQ19) list ascending, may wrap to zero
// (RQ20) unused low bits of last byte zero
module mprf_framer #(
    parameter int MAX_PAGES = mprf_pkg::DEF_MAX_PAGES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_last,
    output logic rx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    input wire logic [3:0] upg_state,
    input wire logic crc_busy,
    input wire logic [31:0] image_pages,
    input wire logic [1:0] plen_sel,
    input wire logic prefer_list,
    input wire logic [31:0] image_crc,
    input wire logic [15:0] exc_code,
    input wire logic page_mark,
    input wire logic [31:0] page_mark_num,
    input wire logic image_clear,
    output logic [31:0] rcv_count,
    output logic busy
);
    localparam int AW = $clog2(MAX_PAGES);
    localparam int PW = AW + 1;

    generate
        if (MAX_PAGES < 8 || (1 << AW) != MAX_PAGES) begin : g_bad_pages
            $error("MAX_PAGES must be a power of two of at least 8");
        end
    endgenerate

    // (RQ17) page length decode
    function automatic logic [7:0] plen_bytes(input logic [1:0] sel);
        case (sel)
            2'h0: plen_bytes = mprf_pkg::PLEN_32;
            2'h1: plen_bytes = mprf_pkg::PLEN_64;
            2'h2: plen_bytes = mprf_pkg::PLEN_128;
            default: plen_bytes = mprf_pkg::PLEN_192;
        endcase
    endfunction : plen_bytes

    mprf_pkg::mprf_state_t state_ff;
    mprf_pkg::mprf_fld_t fld_ff;
    logic [MAX_PAGES-1:0] rcv_map_ff;
    logic [31:0] rcv_cnt_ff;
    logic hdr_ok_ff;
    logic [2:0] rx_idx_ff;
    logic [31:0] qpage_ff;
    logic [PW-1:0] cur_ff;
    logic [PW-1:0] scan_ff;
    logic [PW-1:0] pend_ff;
    logic [PW-1:0] bit_ctr_ff;
    logic [PW-1:0] nbits_ff;
    logic [5:0] ent_ff;
    logic [6:0] acc_ff;
    logic [31:0] word_ff;
    logic [1:0] bidx_ff;
    logic [1:0] nlast_ff;
    logic fin_ff;
    logic list_ff;
    logic empty_ff;
    logic sreply_ff;

    // image sizes beyond the map are clipped; such pages never show missing
    wire [31:0] max_pages32 = 32'(MAX_PAGES);
    wire [PW-1:0] pages_w = (image_pages > max_pages32) ? max_pages32[PW-1:0]
                                                         : image_pages[PW-1:0];
    wire [31:0] pages32 = 32'(pages_w);
    wire [7:0] plen_w = plen_bytes(plen_sel);
    wire [31:0] bits_cap32 = {21'h0, plen_w, 3'h0};
    wire [31:0] nbits32 = (pages32 < bits_cap32) ? pages32 : bits_cap32;
    wire [5:0] max_ent_w = plen_w[7:2];

    // (RQ11) a page is missing when not marked received
    wire miss_w = (cur_ff < pages_w) && !rcv_map_ff[cur_ff[AW-1:0]];
    // (RQ12) page walk wraps from the last page to page zero
    wire [PW-1:0] cur_next = (cur_ff + 1'b1 == pages_w) ? '0 : cur_ff + 1'b1;
    // (RQ9) a query at or past the end restarts at zero
    wire [PW-1:0] q_start = (qpage_ff < pages32) ? qpage_ff[PW-1:0] : '0;

    wire rx_take = rx_valid && rx_ready;
    wire [3:0] rx_type = rx_data[mprf_pkg::HDR_TYPE_MSB:mprf_pkg::HDR_TYPE_LSB];
    wire [1:0] rx_ver = rx_data[mprf_pkg::HDR_VER_MSB:mprf_pkg::HDR_VER_LSB];
    wire rx_final = (rx_idx_ff == mprf_pkg::QUERY_LAST_IDX);

    wire bit_last = (bit_ctr_ff == nbits_ff - 1'b1);
    wire byte_end = (&bit_ctr_ff[2:0]) || bit_last;
    // (RQ10) first page lands in the msb of each byte
    // (RQ20) shift leaves zero padding in the low bits
    wire [7:0] bits_byte = {acc_ff, miss_w} << (3'h7 - bit_ctr_ff[2:0]);
    wire word_end = (bidx_ff == nlast_ff);
    wire list_lim = (scan_ff == pages_w) || (ent_ff == max_ent_w - 6'h1);

    // (RQ14) reply form follows the prefer_list input
    wire [3:0] hdr_type = sreply_ff ? mprf_pkg::TYPE_STATE
                        : (list_ff ? mprf_pkg::TYPE_LIST : mprf_pkg::TYPE_BITMAP);
    // (RQ4) header byte with zero version and reserved bits
    wire [7:0] hdr_byte = {hdr_type, mprf_pkg::PROTO_VERSION, mprf_pkg::HDR_RESERVED};

    wire push_valid = (state_ff == mprf_pkg::MPRF_S_HDR)
                   || (state_ff == mprf_pkg::MPRF_S_WORD)
                   || (state_ff == mprf_pkg::MPRF_S_BITS && byte_end);
    wire [7:0] push_data = (state_ff == mprf_pkg::MPRF_S_HDR) ? hdr_byte
                         : (state_ff == mprf_pkg::MPRF_S_WORD) ? word_ff[31:24]
                         : bits_byte;
    wire push_last = ((state_ff == mprf_pkg::MPRF_S_WORD) && fin_ff && word_end)
                  || ((state_ff == mprf_pkg::MPRF_S_BITS) && bit_last);
    wire push_ready;
    wire push_fire = push_valid && push_ready;

    assign rx_ready = (state_ff == mprf_pkg::MPRF_S_PARSE)
                   || (state_ff == mprf_pkg::MPRF_S_DROP);
    assign busy = !rx_ready;
    assign rcv_count = rcv_cnt_ff;

    mprf_buf #(
        .WIDTH(9)
    ) u_txbuf (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_data({push_last, push_data}),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .out_data({tx_last, tx_data}),
        .out_valid(tx_valid),
        .out_ready(tx_ready)
    );

    wire mark_ok = page_mark && (page_mark_num < max_pages32)
                && !rcv_map_ff[page_mark_num[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (sys_rst || image_clear) begin
            rcv_map_ff <= '0;
            rcv_cnt_ff <= mprf_pkg::RCV_COUNT_RST;
        end else if (mark_ok) begin
            rcv_map_ff[page_mark_num[AW-1:0]] <= 1'b1;
            rcv_cnt_ff <= rcv_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= mprf_pkg::MPRF_S_PARSE;
            fld_ff <= mprf_pkg::MPRF_F_COUNT;
            hdr_ok_ff <= 1'b0;
            rx_idx_ff <= 3'h0;
            qpage_ff <= 32'h0;
            cur_ff <= '0;
            scan_ff <= '0;
            pend_ff <= '0;
            bit_ctr_ff <= '0;
            nbits_ff <= '0;
            ent_ff <= 6'h0;
            acc_ff <= 7'h0;
            word_ff <= 32'h0;
            bidx_ff <= 2'h0;
            nlast_ff <= 2'h0;
            fin_ff <= 1'b0;
            list_ff <= 1'b0;
            empty_ff <= 1'b0;
            sreply_ff <= 1'b0;
        end else begin
            case (state_ff)
                mprf_pkg::MPRF_S_PARSE: begin
                    if (rx_take) begin
                        rx_idx_ff <= rx_idx_ff + 3'h1;
                        if (rx_idx_ff == 3'h0) begin
                            // (RQ4) only a type 7, version 0 header counts
                            hdr_ok_ff <= (rx_type == mprf_pkg::TYPE_QUERY)
                                      && (rx_ver == mprf_pkg::PROTO_VERSION);
                        end else begin
                            // (RQ5) page number, most significant byte first
                            qpage_ff <= {qpage_ff[23:0], rx_data};
                        end
                        if (rx_last) begin
                            rx_idx_ff <= 3'h0;
                            if (rx_final && hdr_ok_ff) begin
                                state_ff <= mprf_pkg::MPRF_S_START;
                            end
                        end else if (rx_final) begin
                            // overlong frames are thrown away unanswered
                            state_ff <= mprf_pkg::MPRF_S_DROP;
                        end
                    end
                end
                mprf_pkg::MPRF_S_DROP: begin
                    rx_idx_ff <= 3'h0;
                    if (rx_take && rx_last) begin
                        state_ff <= mprf_pkg::MPRF_S_PARSE;
                    end
                end
                mprf_pkg::MPRF_S_START: begin
                    list_ff <= prefer_list;
                    empty_ff <= 1'b0;
                    cur_ff <= q_start;
                    scan_ff <= '0;
                    // (RQ3) not receiving: state reply
                    sreply_ff <= (upg_state != mprf_pkg::UPG_RECEIVING);
                    if (upg_state != mprf_pkg::UPG_RECEIVING) begin
                        state_ff <= mprf_pkg::MPRF_S_HDR;
                    end else if (crc_busy) begin
                        // (RQ16) checksum running: empty report
                        empty_ff <= 1'b1;
                        state_ff <= mprf_pkg::MPRF_S_HDR;
                    end else begin
                        state_ff <= mprf_pkg::MPRF_S_SEARCH;
                    end
                end
                mprf_pkg::MPRF_S_SEARCH: begin
                    // (RQ8) first missing page at or after the query
                    if (scan_ff == pages_w) begin
                        empty_ff <= 1'b1;
                        state_ff <= mprf_pkg::MPRF_S_HDR;
                    end else if (miss_w) begin
                        state_ff <= mprf_pkg::MPRF_S_HDR;
                    end else begin
                        // (RQ9) search wraps on to page zero
                        cur_ff <= cur_next;
                        scan_ff <= scan_ff + 1'b1;
                    end
                end
                mprf_pkg::MPRF_S_HDR: begin
                    if (push_fire) begin
                        state_ff <= mprf_pkg::MPRF_S_WORD;
                        bidx_ff <= 2'h0;
                        if (sreply_ff) begin
                            fld_ff <= mprf_pkg::MPRF_F_STATE;
                            word_ff <= {upg_state, 4'h0, 24'h0};
                            nlast_ff <= 2'h0;
                            fin_ff <= 1'b0;
                        end else begin
                            // (RQ6) received page count follows the header
                            fld_ff <= mprf_pkg::MPRF_F_COUNT;
                            word_ff <= rcv_cnt_ff;
                            nlast_ff <= 2'h3;
                            fin_ff <= list_ff && empty_ff;
                        end
                    end
                end
                mprf_pkg::MPRF_S_WORD: begin
                    if (push_fire && !word_end) begin
                        word_ff <= {word_ff[23:0], 8'h0};
                        bidx_ff <= bidx_ff + 2'h1;
                    end else if (push_fire) begin
                        bidx_ff <= 2'h0;
                        // (RQ2) a final byte ends the one reply
                        if (fin_ff) begin
                            state_ff <= mprf_pkg::MPRF_S_PARSE;
                        end else begin
                            case (fld_ff)
                                mprf_pkg::MPRF_F_STATE: begin
                                    fld_ff <= mprf_pkg::MPRF_F_CRC;
                                    word_ff <= image_crc;
                                    nlast_ff <= 2'h3;
                                    fin_ff <= (upg_state != mprf_pkg::UPG_EXCEPTION);
                                end
                                mprf_pkg::MPRF_F_CRC: begin
                                    fld_ff <= mprf_pkg::MPRF_F_EXC;
                                    word_ff <= {exc_code, 16'h0};
                                    nlast_ff <= 2'h1;
                                    fin_ff <= 1'b1;
                                end
                                mprf_pkg::MPRF_F_COUNT: begin
                                    if (list_ff) begin
                                        pend_ff <= cur_ff;
                                        cur_ff <= cur_next;
                                        scan_ff <= {{(PW-1){1'b0}}, 1'b1};
                                        ent_ff <= 6'h0;
                                        state_ff <= mprf_pkg::MPRF_S_LSCAN;
                                    end else begin
                                        // (RQ7) number of the first bitmap page
                                        fld_ff <= mprf_pkg::MPRF_F_FIRST;
                                        word_ff <= empty_ff ? qpage_ff : 32'(cur_ff);
                                        nlast_ff <= 2'h3;
                                        fin_ff <= empty_ff;
                                    end
                                end
                                mprf_pkg::MPRF_F_FIRST: begin
                                    // (RQ13) bit count capped at page length bytes
                                    nbits_ff <= nbits32[PW-1:0];
                                    bit_ctr_ff <= '0;
                                    acc_ff <= 7'h0;
                                    state_ff <= mprf_pkg::MPRF_S_BITS;
                                end
                                mprf_pkg::MPRF_F_LIST: begin
                                    ent_ff <= ent_ff + 6'h1;
                                    state_ff <= mprf_pkg::MPRF_S_LSCAN;
                                end
                                default: begin
                                    state_ff <= mprf_pkg::MPRF_S_PARSE;
                                end
                            endcase
                        end
                    end
                end
                mprf_pkg::MPRF_S_BITS: begin
                    // receiver stall holds the walk only at byte boundaries
                    if (!byte_end || push_ready) begin
                        acc_ff <= byte_end ? 7'h0 : {acc_ff[5:0], miss_w};
                        cur_ff <= cur_next;
                        bit_ctr_ff <= bit_ctr_ff + 1'b1;
                        if (bit_last) begin
                            state_ff <= mprf_pkg::MPRF_S_PARSE;
                        end
                    end
                end
                mprf_pkg::MPRF_S_LSCAN: begin
                    // one entry held back so the final one can carry last
                    // (RQ18) entries go out as 32-bit words
                    fld_ff <= mprf_pkg::MPRF_F_LIST;
                    word_ff <= 32'(pend_ff);
                    nlast_ff <= 2'h3;
                    if (list_lim) begin
                        fin_ff <= 1'b1;
                        state_ff <= mprf_pkg::MPRF_S_WORD;
                    end else begin
                        // (RQ19) ascending walk, wrapping to zero
                        cur_ff <= cur_next;
                        scan_ff <= scan_ff + 1'b1;
                        if (miss_w) begin
                            fin_ff <= 1'b0;
                            pend_ff <= cur_ff;
                            state_ff <= mprf_pkg::MPRF_S_WORD;
                        end
                    end
                end
                default: begin
                    state_ff <= mprf_pkg::MPRF_S_PARSE;
                end
            endcase
        end
    end

endmodule : mprf_framer

// *** verif/mprf_chk.sv ***
`timescale 1ns/1ps

module mprf_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic [3:0] upg_state,
    input wire logic [1:0] plen_sel,
    input wire logic prefer_list,
    input wire logic page_mark,
    input wire logic image_clear,
    input wire logic [31:0] rcv_count,
    input wire logic busy
);
    logic sof_ff;
    logic [8:0] cnt_ff;
    logic [7:0] pend_ff;
    wire take = tx_valid && tx_ready;
    wire [8:0] plen = (plen_sel == 2'h3) ? 9'h0c0 : (9'h020 << plen_sel);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sof_ff <= 1'b1;
            cnt_ff <= 9'h000;
            pend_ff <= 8'h00;
        end else begin
            if (take) begin
                sof_ff <= tx_last;
                cnt_ff <= tx_last ? 9'h000 : cnt_ff + 9'h001;
            end
            // replies owed: one per accepted query
            pend_ff <= pend_ff + 8'($rose(busy)) - 8'(take && tx_last);
        end
    end
    hdr_zero_a: assert property (take && sof_ff |-> tx_data[3:0] == 4'h0)
        else $error("header bits not zero");
    state_type_a: assert property (take && sof_ff && upg_state != mprf_pkg::UPG_RECEIVING
        |-> tx_data[7:4] == mprf_pkg::TYPE_STATE) else $error("state reply type wrong");
    report_type_a: assert property (take && sof_ff && upg_state == mprf_pkg::UPG_RECEIVING
        |-> tx_data[7:4] == (prefer_list ? mprf_pkg::TYPE_LIST : mprf_pkg::TYPE_BITMAP))
        else $error("report type wrong");
    reply_start_a: assert property ($rose(busy) |-> ##[1:150] (tx_valid && sof_ff))
        else $error("no reply after query");
    one_reply_a: assert property (take && tx_last |-> pend_ff != 8'h00)
        else $error("reply without query");
    tx_hold_a: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("stalled byte lost");
    frame_len_a: assert property (take |-> cnt_ff < 9'h009 + plen)
        else $error("reply too long");
    count_cause_a: assert property ($changed(rcv_count) |-> $past(page_mark) || $past(image_clear))
        else $error("count moved");
    count_clear_a: assert property (image_clear |=> rcv_count == 32'h0)
        else $error("count not cleared");
    count_step_a: assert property (page_mark && !image_clear
        |=> rcv_count - $past(rcv_count) <= 32'h1) else $error("count jumped");
endmodule : mprf_chk

bind mprf_framer mprf_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .upg_state(upg_state),
    .plen_sel(plen_sel), .prefer_list(prefer_list), .page_mark(page_mark),
    .image_clear(image_clear), .rcv_count(rcv_count), .busy(busy));

// *** verif/mprf_base_node.sv ***
`timescale 1ns/1ps

module mprf_base_node (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic stall,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_last,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready
);
    logic [7:0] got[$];
    int nfr = 0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_last = 1'b0;
        tx_ready = 1'b0;
    end
    task automatic send(input logic [47:0] fr, input int n);
        for (int i = 0; i < n; i++) begin
            rx_data <= fr[47-8*i -: 8];
            rx_valid <= 1'b1;
            rx_last <= (i == n - 1);
            do @(negedge core_clk); while (!rx_ready);
            @(posedge core_clk);
        end
        rx_data <= ~rx_data;
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
    endtask : send
    always @(posedge core_clk) begin
        tx_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
        if (sys_rst) begin
            got.delete();
        end else if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            if (tx_last) nfr <= nfr + 1;
        end
    end
endmodule : mprf_base_node

// *** verif/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] upg_state = 4'h1;
    logic crc_busy = 1'b0;
    logic [31:0] image_pages = 32'h0000_0040;
    logic [1:0] plen_sel = 2'h0;
    logic prefer_list = 1'b0;
    logic [31:0] image_crc = 32'h0;
    logic [15:0] exc_code = 16'h0;
    logic page_mark = 1'b0;
    logic [31:0] page_mark_num = 32'h0;
    logic image_clear = 1'b0;
    logic [7:0] rx_data, tx_data;
    logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, busy;
    logic [31:0] rcv_count;
    logic [7:0] exp[$];
    bit miss[64];
    int n_errors = 0, num_checks = 0, rcnt = 0;
    always #2 core_clk = ~core_clk;
    mprf_framer #(.MAX_PAGES(64)) dut (.*);
    mprf_base_node u_base (.stall(1'b1), .*);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, want, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    function automatic void put32(input logic [31:0] v);
        for (int i = 3; i >= 0; i--) exp.push_back(v[8*i +: 8]);
    endfunction : put32
    task automatic fill(input int n, input int pct);
        bit m;
        image_clear <= 1'b1;
        @(posedge core_clk);
        image_clear <= 1'b0;
        foreach (miss[i]) miss[i] = 1'b1;
        rcnt = 0;
        for (int p = 0; p < n; p++) begin
            m = ($urandom_range(99) < pct);
            page_mark <= m;
            page_mark_num <= p;
            rcnt += (m && miss[p]);
            if (m) miss[p] = 1'b0;
            @(posedge core_clk);
        end
        // out of range page is ignored
        page_mark <= 1'b1;
        page_mark_num <= 32'h0000_0100;
        @(posedge core_clk);
        page_mark <= 1'b0;
    endtask : fill
    task automatic query(input logic [31:0] pg);
        int n0, t, f, nb, k, nn, pl;
        logic [7:0] b;
        n0 = u_base.nfr;
        u_base.got.delete();
        u_base.send({8'h70, pg, 8'h00}, 5);
        for (t = 0; t < 3000 && u_base.nfr == n0; t++) @(posedge core_clk);
        nn = image_pages;
        pl = (plen_sel == 2'h3) ? 192 : (32 << plen_sel);
        exp = {};
        if (upg_state != mprf_pkg::UPG_RECEIVING) begin
            exp.push_back(8'h50);
            exp.push_back({upg_state, 4'h0});
            put32(image_crc);
            if (upg_state == mprf_pkg::UPG_EXCEPTION) exp = {exp, exc_code[15:8], exc_code[7:0]};
        end else begin
            exp.push_back(prefer_list ? 8'h90 : 8'h80);
            put32(rcnt);
            f = -1;
            for (int i = (pg < nn) ? pg : 0; i < nn; i++) if (miss[i] && f < 0) f = i;
            for (int i = 0; i < nn; i++) if (miss[i] && f < 0) f = i;
            if (crc_busy || f < 0) begin
                if (!prefer_list) put32(pg);
            end else if (!prefer_list) begin
                put32(f);
                nb = (nn < 8 * pl) ? nn : 8 * pl;
                for (int i = 0; i < nb; i++) begin
                    if (i % 8 == 0) b = 8'h00;
                    b[7 - i % 8] = miss[(f + i) % nn];
                    if (i % 8 == 7 || i == nb - 1) exp.push_back(b);
                end
            end else begin
                k = 0;
                for (int i = 0; i < nn; i++) begin
                    if (miss[(f + i) % nn] && k < pl / 4) put32((f + i) % nn);
                    k += miss[(f + i) % nn];
                end
            end
        end
        chk("replies", u_base.nfr, n0 + 1);
        chk("length", u_base.got.size(), exp.size());
        foreach (exp[i]) chk("byte", u_base.got[i], exp[i]);
    endtask : query
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(58920));
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        u_base.send({8'h60, 40'h0}, 5);
        u_base.send({8'h74, 40'h0}, 5);
        u_base.send({8'h70, 40'h0}, 6);
        u_base.send({8'h70, 40'h0}, 3);
        repeat (100) @(posedge core_clk);
        chk("dropped", u_base.nfr, 32'h0);
        $display("malformed frame test done");
        for (int it = 0; it < 60; it++) begin
            image_pages <= $urandom_range(8, 64);
            plen_sel <= 2'($urandom_range(3));
            prefer_list <= 1'($urandom_range(1));
            crc_busy <= (it % 8 == 6);
            upg_state <= (it % 4 == 1) ? 4'((it / 4) % 6) : mprf_pkg::UPG_RECEIVING;
            image_crc <= $urandom();
            exc_code <= 16'($urandom());
            @(posedge core_clk);
            fill(image_pages, (it % 8 == 3) ? 100 : $urandom_range(99));
            @(negedge core_clk);
            chk("count", rcv_count, rcnt);
            @(posedge core_clk);
            query($urandom_range(70));
            $display("query test %0d done", it);
        end
        stop_test();
    end
endmodule : tb_top
